// ---- test/pts_chk.sv ----
// Port checker for the transmit slot control block
`timescale 1ns/10ps
module pts_chk (
  input wire logic        clk,        // Clock
  input wire logic        srst,       // Reset
  input wire logic        psel,       // Select
  input wire logic        penable,    // Access
  input wire logic        pwrite,     // Write
  input wire logic [11:0] paddr,      // Address
  input wire logic [31:0] pwdata,     // Data
  input wire logic        pslverr,    // Error
  input wire logic        bclkPin,    // Bit clock
  input wire logic        sampleTake, // Capture
  input wire logic        txData,     // Data out
  input wire logic        txDataOe,   // Driving
  input wire logic        frameActive // In frame
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic [15:0] en, fl;
  logic        pol, gen;
  wire         wr  = psel && penable && pwrite;
  wire         hit = paddr inside {pts_pkg::OFS_CLK_SETUP, pts_pkg::OFS_EN_LOW,
    pts_pkg::OFS_EN_HIGH, pts_pkg::OFS_FLOAT_LOW, pts_pkg::OFS_FLOAT_HIGH, pts_pkg::OFS_STATUS,
    pts_pkg::OFS_LANE0_MAP, pts_pkg::OFS_LANE1_MAP, pts_pkg::OFS_LANE2_MAP, pts_pkg::OFS_GLOBAL_EN};
  // Shadow settings so slot checks know what the device runs with
  always_ff @(posedge clk) begin
    if (srst) begin
      {en, fl, pol, gen} <= '0;
    end else if (wr) begin
      case (paddr)
        pts_pkg::OFS_EN_LOW:     en[7:0]  <= pwdata[7:0];
        pts_pkg::OFS_EN_HIGH:    en[15:8] <= pwdata[7:0];
        pts_pkg::OFS_FLOAT_LOW:  fl[7:0]  <= pwdata[7:0];
        pts_pkg::OFS_FLOAT_HIGH: fl[15:8] <= pwdata[7:0];
        pts_pkg::OFS_CLK_SETUP:  pol      <= pwdata[pts_pkg::POL_BIT];
        pts_pkg::OFS_GLOBAL_EN:  gen      <= pwdata[pts_pkg::GLOBAL_EN_BIT];
        default: ;
      endcase
    end
  end
  sequence s_pulse; sampleTake ##1 !sampleTake; endsequence
  property p_err; pslverr == (psel && penable && !hit); endproperty
  a_err: assert property (p_err) else $error("bad pslverr");
  property p_take; $rose(sampleTake) |-> s_pulse; endproperty
  a_take: assert property (p_take) else $error("long capture pulse");
  property p_tkFrame; sampleTake |-> ##[0:1] frameActive; endproperty
  a_tkFrame: assert property (p_tkFrame) else $error("capture outside frame");
  property p_idle; !frameActive |-> !txDataOe; endproperty
  a_idle: assert property (p_idle) else $error("driven outside frame");
  property p_gen; !gen |=> !frameActive && !txDataOe; endproperty
  a_gen: assert property (p_gen) else $error("sends while off");
  property p_float; frameActive && !txDataOe |-> |(fl & ~en); endproperty
  a_float: assert property (p_float) else $error("bad release");
  property p_low; frameActive && txDataOe && txData |-> |en; endproperty
  a_low: assert property (p_low) else $error("idle slot not low");
  property p_edge; frameActive && $changed(txData) |-> bclkPin == pol; endproperty
  a_edge: assert property (p_edge) else $error("wrong launch edge");
endmodule : pts_chk

bind pts_tx_slot_ctrl pts_chk i_chk (
  .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pslverr(pslverr), .bclkPin(bclkPin), .sampleTake(sampleTake),
  .txData(txData), .txDataOe(txDataOe), .frameActive(frameActive));

// ---- test/pts_codec.sv ----
// Codec model: makes bit clock and frame sync, captures the line
`timescale 1ns/10ps
module pts_codec #(
  parameter int NB = 64  // Bits per frame
) (
  input  wire logic txData, // Data
  input  wire logic txOe,   // Driving
  output logic      bclk,   // Bit clock
  output logic      fsync   // Frame sync
);
  logic [1:0] rx [NB+1];
  initial begin
    bclk  = 1'b1;
    fsync = 1'b0;
  end
  // Clock stands still between frames; a spare bit lets the device close the frame
  task automatic frame(input logic pol);
    bclk = !pol;
    #500;
    for (int i = 0; i <= NB; i++) begin
      fsync = (i == 0);
      #20;
      bclk = pol;
      #42.5;
      bclk = !pol;
      rx[i] = {txOe, txData & txOe};
      #62.5;
    end
  endtask : frame
endmodule : pts_codec

// ---- test/testbench.sv ----
// Self-checking bench for the transmit slot control block
`timescale 1ns/10ps
module testbench;
  localparam int SB = 4;
  logic          clk, srst, psel, penable, pwrite, pready, pslverr, se, pol, g;
  logic          sampleTake, txData, txDataOe, frameActive, bclkPin, fsyncPin;
  logic [11:0]   paddr, a;
  logic [31:0]   pwdata, prdata, rd, d;
  logic [SB-1:0] bus_tx_sample_lane0, bus_tx_sample_lane1, bus_tx_sample_lane2;
  logic [15:0]   en, fl;
  logic [7:0]    mp [3];
  int            errCount, samplesChecked, seed, i, k;

  pts_tx_slot_ctrl #(.SLOT_BITS(SB)) i_dut (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bclkPin(bclkPin),
    .fsyncPin(fsyncPin), .bus_tx_sample_lane0(bus_tx_sample_lane0),
    .bus_tx_sample_lane1(bus_tx_sample_lane1), .bus_tx_sample_lane2(bus_tx_sample_lane2),
    .sampleTake(sampleTake), .txData(txData), .txDataOe(txDataOe), .frameActive(frameActive));
  pts_codec #(.NB(16 * SB)) i_codec (.txData(txData), .txOe(txDataOe), .bclk(bclkPin),
    .fsync(fsyncPin));

  initial begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end

  task automatic finalReport();
    $display("checks %0d mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finalReport

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samplesChecked++;
    if (seen !== exp) begin
      errCount++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One idle cycle between transfers keeps psel from being driven twice in a step
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] v);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= v;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errCount++;
      finalReport();
    end
    se      = pslverr;
    rd      = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Returns {driving, data} for one bit of a slot
  function automatic logic [1:0] want(input int s, input int b);
    logic [SB-1:0] smp [3];
    smp = '{bus_tx_sample_lane0, bus_tx_sample_lane1, bus_tx_sample_lane2};
    if (!g) return 2'b00;
    if (!en[s]) return fl[s] ? 2'b00 : 2'b10;
    for (int n = 0; n < 3; n++) begin
      if (mp[n][7] && mp[n][3:0] == s) return {1'b1, smp[n][SB-1-b]};
    end
    return 2'b10;
  endfunction : want

  initial begin
    seed = 32'h040C;
    errCount = 0;
    samplesChecked = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {bus_tx_sample_lane0, bus_tx_sample_lane1, bus_tx_sample_lane2} = '0;
    srst = 1'b1;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    for (i = 0; i < 7; i++) begin
      a = pts_pkg::OFS_EN_LOW + 12'(4 * i);
      apb(0, a, 32'h0);
      check(rd, 32'h0, "reset value");
      d = $random(seed);
      apb(1, a, d);
      apb(0, a, 32'h0);
      check(rd, d & (i < 4 ? 32'hFF : 32'h8F), "read back");
    end
    apb(1, 12'h0F0, 32'hFFFFFFFF);
    check(32'(se), 32'h1, "unmapped error");
    apb(0, 12'h0F0, 32'h0);
    check(rd, 32'h0, "unmapped read");
    apb(0, pts_pkg::OFS_STATUS, 32'h0);
    check(rd, 32'h0, "status after reset");
    for (k = 0; k < 6; k++) begin
      en  = k < 2 ? 16'h0000 : (k == 2 ? 16'hFFFF : 16'($random(seed)));
      fl  = k == 0 ? 16'h0000 : (k < 3 ? 16'hFFFF : 16'($random(seed)));
      pol = k[0];
      g   = (k != 5);
      apb(1, pts_pkg::OFS_CLK_SETUP, 32'(pol) << pts_pkg::POL_BIT);
      apb(1, pts_pkg::OFS_GLOBAL_EN, 32'(g));
      apb(1, pts_pkg::OFS_EN_LOW, 32'(en[7:0]));
      apb(1, pts_pkg::OFS_EN_HIGH, 32'(en[15:8]));
      apb(1, pts_pkg::OFS_FLOAT_LOW, 32'(fl[7:0]));
      apb(1, pts_pkg::OFS_FLOAT_HIGH, 32'(fl[15:8]));
      // Shared slots on purpose, so lane priority is exercised
      for (i = 0; i < 3; i++) begin
        mp[i] = k == 2 ? 8'h83 : 8'($random(seed)) & 8'h87;
        apb(1, pts_pkg::OFS_LANE0_MAP + 12'(4 * i), 32'(mp[i]));
      end
      apb(0, pts_pkg::OFS_CLK_SETUP, 32'h0);
      check(rd, 32'(pol) << pts_pkg::POL_BIT, "polarity");
      apb(0, pts_pkg::OFS_GLOBAL_EN, 32'h0);
      check(rd, 32'(g), "global enable");
      bus_tx_sample_lane0 <= SB'($random(seed));
      bus_tx_sample_lane1 <= SB'($random(seed));
      bus_tx_sample_lane2 <= SB'($random(seed));
      // Status is read part way through the frame, while the codec clocks
      fork
        i_codec.frame(pol);
        begin
          repeat (300) @(posedge clk);
          apb(0, pts_pkg::OFS_STATUS, 32'h0);
          check(rd & 32'h1, 32'(g), "frame active");
        end
      join
      for (i = 0; i < 16 * SB; i++) begin
        check(32'(i_codec.rx[i]), 32'(want(i / SB, i % SB)), "bit");
      end
      apb(0, pts_pkg::OFS_STATUS, 32'h0);
      check(rd & 32'h1, 32'h0, "frame closed");
    end
    finalReport();
  end
endmodule : testbench

// ---- verilog/pts_pkg.sv ----
// Constants shared by the transmit slot control block
package pts_pkg;

  // Register bus geometry
  localparam int          ADDR_W = 12;
  localparam int          DATA_W = 32;

  // Register byte offsets
  localparam logic [11:0] OFS_CLK_SETUP   = 12'h0BC;
  localparam logic [11:0] OFS_EN_LOW      = 12'h0D4;
  localparam logic [11:0] OFS_EN_HIGH     = 12'h0D8;
  localparam logic [11:0] OFS_FLOAT_LOW   = 12'h0DC;
  localparam logic [11:0] OFS_FLOAT_HIGH  = 12'h0E0;
  localparam logic [11:0] OFS_LANE0_MAP   = 12'h0E4;
  localparam logic [11:0] OFS_LANE1_MAP   = 12'h0E8;
  localparam logic [11:0] OFS_LANE2_MAP   = 12'h0EC;
  localparam logic [11:0] OFS_GLOBAL_EN   = 12'h118;
  localparam logic [11:0] OFS_STATUS      = 12'h120;

  // Field positions
  localparam int          POL_BIT         = 4;
  localparam int          GLOBAL_EN_BIT   = 0;
  localparam int          LANE_ON_BIT     = 7;
  localparam int          SLOT_IDX_MSB    = 3;
  localparam int          STAT_ACTIVE_BIT = 0;
  localparam int          STAT_SLOT_LSB   = 4;
  localparam int          STAT_SLOT_MSB   = 7;

  // Values after reset
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [7:0]  RST_LANE_MAP    = 8'h00;
  localparam logic        RST_POL         = 1'b0;
  localparam logic        RST_GLOBAL_EN   = 1'b0;

  // Frame shape
  localparam int          NUM_CH          = 16;
  localparam int          NUM_LANES       = 3;
  localparam int          SLOT_BITS_DEF   = 16;

endpackage : pts_pkg

// ---- verilog/pts_tx_slot_ctrl.sv ----
// Transmit slot control: channel enables, idle-slot float, lane to slot mapping
`timescale 1ns/10ps

module pts_tx_slot_ctrl #(
  parameter int SLOT_BITS = pts_pkg::SLOT_BITS_DEF  // Bits per slot and per sample
) (
  input  wire logic                  clk,                  // System clock, 100 MHz
  input  wire logic                  srst,                 // Synchronous reset, active high
  input  wire logic                  psel,                 // APB select
  input  wire logic                  penable,              // APB access phase
  input  wire logic                  pwrite,               // APB direction, high = write
  input  wire logic [11:0]           paddr,                // APB byte address
  input  wire logic [31:0]           pwdata,               // APB write data
  output logic      [31:0]           prdata,               // APB read data
  output logic                       pready,               // APB ready
  output logic                       pslverr,              // APB error, unmapped address
  input  wire logic                  bclkPin,              // Serial bit clock from the codec
  input  wire logic                  fsyncPin,             // Frame sync from the codec
  input  wire logic [SLOT_BITS-1:0]  bus_tx_sample_lane0,  // Lane 0 sample
  input  wire logic [SLOT_BITS-1:0]  bus_tx_sample_lane1,  // Lane 1 sample
  input  wire logic [SLOT_BITS-1:0]  bus_tx_sample_lane2,  // Lane 2 sample
  output logic                       sampleTake,           // Pulses the cycle after samples are captured
  output logic                       txData,               // Serial data out
  output logic                       txDataOe,             // Serial data output enable
  output logic                       frameActive           // Inside the sixteen slots
);

  localparam int BW = (SLOT_BITS > 1) ? $clog2(SLOT_BITS) : 1;
  localparam int NL = pts_pkg::NUM_LANES;
  localparam logic [BW-1:0] LAST_BIT = BW'(SLOT_BITS - 1);
  localparam logic [3:0]    LAST_SLOT = 4'(pts_pkg::NUM_CH - 1);

  // Register state
  logic [7:0]            enLow;
  logic [7:0]            enHigh;
  logic [7:0]            floatLow;
  logic [7:0]            floatHigh;
  logic [7:0]            laneMap [NL];
  logic                  bclkPol;
  logic                  globalEn;

  // Derived configuration
  logic [15:0]           chanEn;
  logic [15:0]           chanFloat;
  logic [NL-1:0]         laneOn;
  logic [3:0]            laneSlot [NL];

  // Bus decode
  logic                  wrStrobe;
  logic                  addrHit;
  logic [31:0]           readMux;

  // Link sampling
  logic                  bclkMeta;
  logic                  bclkSync;
  logic                  bclkLast;
  logic                  fsyncMeta;
  logic                  fsyncSync;
  logic                  fsyncPrev;
  logic                  bclkRise;
  logic                  bclkFall;
  logic                  launchEdge;
  logic                  frameStart;
  // Marks which sync flops already hold sampled pin values after reset
  logic                  primeMeta;
  logic                  primeSync;
  logic                  primeLast;

  // Frame position
  logic [BW-1:0]         bitIdx;
  logic [3:0]            slotIdx;
  logic [BW-1:0]         next_bitIdx;
  logic [3:0]            next_slotIdx;
  logic                  next_active;

  // Sample shadows and slot owner
  logic [SLOT_BITS-1:0]  busSample [NL];
  logic [SLOT_BITS-1:0]  shadow [NL];
  logic [SLOT_BITS-1:0]  ownerWord;
  logic                  ownerHit;
  logic                  next_txData;
  logic                  next_txDataOe;

  assign chanEn    = {enHigh, enLow};
  assign chanFloat = {floatHigh, floatLow};

  assign busSample[0] = bus_tx_sample_lane0;
  assign busSample[1] = bus_tx_sample_lane1;
  assign busSample[2] = bus_tx_sample_lane2;

  // ---------------------------------------------------------------
  // APB slave, zero wait states
  // ---------------------------------------------------------------
  assign pready   = 1'b1;
  assign wrStrobe = psel & penable & pwrite;

  // Channel enables, one byte per register
  always_ff @(posedge clk) begin
    if (srst) begin
      enLow  <= pts_pkg::RST_BYTE;
      enHigh <= pts_pkg::RST_BYTE;
    end else if (wrStrobe && paddr == pts_pkg::OFS_EN_LOW) begin
      enLow  <= pwdata[7:0];
    end else if (wrStrobe && paddr == pts_pkg::OFS_EN_HIGH) begin
      enHigh <= pwdata[7:0];
    end
  end

  // Idle-slot float selects, one byte per register
  always_ff @(posedge clk) begin
    if (srst) begin
      floatLow  <= pts_pkg::RST_BYTE;
      floatHigh <= pts_pkg::RST_BYTE;
    end else if (wrStrobe && paddr == pts_pkg::OFS_FLOAT_LOW) begin
      floatLow  <= pwdata[7:0];
    end else if (wrStrobe && paddr == pts_pkg::OFS_FLOAT_HIGH) begin
      floatHigh <= pwdata[7:0];
    end
  end

  // Link setup; clearing the global enable aborts a running frame at once
  always_ff @(posedge clk) begin
    if (srst) begin
      bclkPol  <= pts_pkg::RST_POL;
      globalEn <= pts_pkg::RST_GLOBAL_EN;
    end else if (wrStrobe && paddr == pts_pkg::OFS_CLK_SETUP) begin
      // Polarity is best changed while the bit clock stands still
      bclkPol  <= pwdata[pts_pkg::POL_BIT];
    end else if (wrStrobe && paddr == pts_pkg::OFS_GLOBAL_EN) begin
      globalEn <= pwdata[pts_pkg::GLOBAL_EN_BIT];
    end
  end

  // One mapping register per transmit lane; reserved bits never stored
  genvar gl;
  generate
    for (gl = 0; gl < NL; gl++) begin : gLane
      always_ff @(posedge clk) begin
        if (srst) begin
          laneMap[gl] <= pts_pkg::RST_LANE_MAP;
        end else if (wrStrobe && paddr == pts_pkg::OFS_LANE0_MAP + 12'(4 * gl)) begin
          laneMap[gl] <= {pwdata[7], 3'h0, pwdata[3:0]};
        end
      end
      assign laneOn[gl]   = laneMap[gl][pts_pkg::LANE_ON_BIT];
      assign laneSlot[gl] = laneMap[gl][pts_pkg::SLOT_IDX_MSB:0];
      always_ff @(posedge clk) begin
        if (srst) begin
          shadow[gl] <= '0;
        end else if (frameStart) begin
          shadow[gl] <= busSample[gl];
        end
      end
    end
  endgenerate

  always_comb begin
    addrHit = 1'b1;
    readMux = 32'h0000_0000;
    unique case (paddr)
      pts_pkg::OFS_EN_LOW:     readMux[7:0] = enLow;
      pts_pkg::OFS_EN_HIGH:    readMux[7:0] = enHigh;
      pts_pkg::OFS_FLOAT_LOW:  readMux[7:0] = floatLow;
      pts_pkg::OFS_FLOAT_HIGH: readMux[7:0] = floatHigh;
      pts_pkg::OFS_LANE0_MAP:  readMux[7:0] = laneMap[0];
      pts_pkg::OFS_LANE1_MAP:  readMux[7:0] = laneMap[1];
      pts_pkg::OFS_LANE2_MAP:  readMux[7:0] = laneMap[2];
      pts_pkg::OFS_CLK_SETUP:  readMux[pts_pkg::POL_BIT] = bclkPol;
      pts_pkg::OFS_GLOBAL_EN:  readMux[pts_pkg::GLOBAL_EN_BIT] = globalEn;
      pts_pkg::OFS_STATUS: begin
        readMux[pts_pkg::STAT_ACTIVE_BIT] = frameActive;
        readMux[pts_pkg::STAT_SLOT_MSB:pts_pkg::STAT_SLOT_LSB] = slotIdx;
      end
      default: addrHit = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~addrHit;

  // Read data is a flop loaded in the setup cycle so it is stable in access
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= readMux;
    end
  end

  // ---------------------------------------------------------------
  // Link sampling: both pins cross through two flops first
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      bclkMeta  <= 1'b0;
      bclkSync  <= 1'b0;
      bclkLast  <= 1'b0;
      fsyncMeta <= 1'b0;
      fsyncSync <= 1'b0;
      primeMeta <= 1'b0;
      primeSync <= 1'b0;
      primeLast <= 1'b0;
    end else begin
      bclkMeta  <= bclkPin;
      bclkSync  <= bclkMeta;
      bclkLast  <= bclkSync;
      fsyncMeta <= fsyncPin;
      fsyncSync <= fsyncMeta;
      primeMeta <= 1'b1;
      primeSync <= primeMeta;
      primeLast <= primeSync;
    end
  end

  // The sync flops leave reset at zero while the pin may idle high; no edge
  // is believed until the whole chain holds sampled pin values
  assign bclkRise   = primeLast & bclkSync & ~bclkLast;
  assign bclkFall   = primeLast & ~bclkSync & bclkLast;
  assign launchEdge = bclkPol ? bclkRise : bclkFall;

  // Frame sync is judged only at launch edges, so its phase against bclk
  // does not matter as long as it holds for one full bit period.
  assign frameStart = globalEn & launchEdge & fsyncSync & ~fsyncPrev;

  always_ff @(posedge clk) begin
    if (srst) begin
      fsyncPrev <= 1'b0;
    end else if (launchEdge) begin
      fsyncPrev <= fsyncSync;
    end
  end

  // ---------------------------------------------------------------
  // Frame position: slot index counted from the frame start
  // ---------------------------------------------------------------
  always_comb begin
    next_bitIdx  = bitIdx;
    next_slotIdx = slotIdx;
    next_active  = frameActive;
    if (!globalEn) begin
      next_active = 1'b0;
    end else if (frameStart) begin
      next_bitIdx  = '0;
      next_slotIdx = 4'h0;
      next_active  = 1'b1;
    end else if (launchEdge && frameActive) begin
      if (bitIdx == LAST_BIT) begin
        next_bitIdx = '0;
        if (slotIdx == LAST_SLOT) begin
          // Bits past the sixteenth slot stay released until the next sync
          next_active = 1'b0;
        end else begin
          next_slotIdx = slotIdx + 4'h1;
        end
      end else begin
        next_bitIdx = bitIdx + BW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bitIdx      <= '0;
      slotIdx     <= 4'h0;
      frameActive <= 1'b0;
    end else begin
      bitIdx      <= next_bitIdx;
      slotIdx     <= next_slotIdx;
      frameActive <= next_active;
    end
  end

  // ---------------------------------------------------------------
  // Slot owner: the lowest enabled lane mapped to this slot
  // ---------------------------------------------------------------
  always_comb begin
    ownerHit  = 1'b0;
    ownerWord = '0;
    for (int l = NL - 1; l >= 0; l--) begin
      if (laneOn[l] && laneSlot[l] == next_slotIdx) begin
        ownerHit  = 1'b1;
        ownerWord = frameStart ? busSample[l] : shadow[l];
      end
    end
  end

  // ---------------------------------------------------------------
  // Driver decision for the coming bit
  // ---------------------------------------------------------------
  always_comb begin
    next_txData   = 1'b0;
    next_txDataOe = 1'b0;
    if (next_active) begin
      if (chanEn[next_slotIdx]) begin
        // An enabled slot with no lane mapped carries zeros, still driven
        next_txDataOe = 1'b1;
        if (ownerHit) begin
          next_txData = ownerWord[LAST_BIT - next_bitIdx];
        end
      end else if (!chanFloat[next_slotIdx]) begin
        next_txDataOe = 1'b1;
      end else begin
        next_txDataOe = 1'b0;
      end
    end
  end

  // Outputs move only at launch edges, or at once when the global enable clears, so the codec sees a whole bit period
  always_ff @(posedge clk) begin
    if (srst) begin
      txData   <= 1'b0;
      txDataOe <= 1'b0;
    end else if (!globalEn) begin
      txData   <= 1'b0;
      txDataOe <= 1'b0;
    end else if (launchEdge) begin
      txData   <= next_txData;
      txDataOe <= next_txDataOe;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sampleTake <= 1'b0;
    end else begin
      sampleTake <= frameStart;
    end
  end

endmodule : pts_tx_slot_ctrl
